// *** rtl/lrc_pkg.sv ***
package lrc_pkg;
  // Reorder memory geometry
  localparam int              LRC_AW        = 3;
  localparam int              LRC_DEPTH     = 8;
  localparam logic [3:0]      LRC_DEPTH_CNT = 4'h8;
  // Defaults for data path
  localparam int              LRC_DW        = 32;
  localparam int              LRC_NOUT      = 2;
  localparam int              LRC_BODY_LAT  = 4;
  // Register byte offsets
  localparam logic [3:0]      LRC_ADDR_CTRL = 4'h0;
  localparam logic [3:0]      LRC_ADDR_STAT = 4'h4;
  localparam logic [3:0]      LRC_ADDR_DONE = 4'h8;
  // Control fields and reset values
  localparam int              LRC_CTRL_EN   = 0;
  localparam logic            LRC_EN_RST    = 1'b1;
  // Status field positions
  localparam int              LRC_STAT_OCC  = 0;
  localparam int              LRC_STAT_RD   = 8;
  localparam int              LRC_STAT_WR   = 16;
  localparam int              LRC_STAT_IDLE = 24;

  // Write index with its validity flag
  typedef struct packed {
    logic              vld;
    logic [LRC_AW-1:0] idx;
  } lrc_widx_t;

  // Wishbone classic request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lrc_wb_req_t;
endpackage

// *** rtl/lrc_reorder_mem.sv ***
module lrc_reorder_mem #(
  parameter int DATA_W = lrc_pkg::LRC_DW
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wr_i,
  input  wire lrc_pkg::lrc_widx_t      wr_addr_i,
  input  wire logic [DATA_W-1:0]       wr_data_i,
  input  wire logic                    rd_en_i,
  input  wire logic [lrc_pkg::LRC_AW-1:0] rd_addr_i,
  output      logic [DATA_W-1:0]       rd_data_o,
  output      logic                    rd_valid_o
);
  logic [DATA_W-1:0]           mem_q [lrc_pkg::LRC_DEPTH];
  logic [lrc_pkg::LRC_DEPTH-1:0] vld_q;
  wire                         wr_en = wr_i & wr_addr_i.vld;

  always_ff @(posedge clk_i)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr_i.idx] <= wr_data_i;
    end
  end

  // Entry flags, set wins over clear
  for (genvar g = 0; g < lrc_pkg::LRC_DEPTH; g++)
  begin : g_ent
    wire set_w = wr_en & (wr_addr_i.idx == lrc_pkg::LRC_AW'(g));
    wire clr_w = rd_en_i & (rd_addr_i == lrc_pkg::LRC_AW'(g));
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        vld_q[g] <= 1'b0;
      else if (set_w)
        vld_q[g] <= 1'b1;
      else if (clr_w)
        vld_q[g] <= 1'b0;
    end
  end

  assign rd_data_o  = mem_q[rd_addr_i];
  assign rd_valid_o = vld_q[rd_addr_i];

  mem_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en |=> vld_q[$past(wr_addr_i.idx)])
    else $error("stored entry not flagged valid");
  mem_nowr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr_en && !vld_q[rd_addr_i]) |=> !vld_q[$past(rd_addr_i)])
    else $error("entry became valid without write");
endmodule

// *** rtl/lrc_loop_ctrl.sv ***
// Summary of operation
// - Selector forwards loop operand when continue condition is 1, else initial operand.
// - Valid and ready are routed by the same condition as the data.
// - Initial operand is taken only for an item's first iteration.
// - No new slot while loop and unread results fill the memory.
// - Write index advances on every slot allocation.
// - Free slots are judged against the read index from the read counter.
// - Every write index carries a valid flag; memory writes need it set.
// - Initial-side ready is high only when a valid slot is available.
// - Write index and flag travel with their data item through the loop.
// - Read ready is high only when every output can accept data.
// - Read index increments on all-ready with valid memory data, else holds.
// - One reorder memory per loop output.
// - Reorder memory depth is at least the body latency.
// - Memory stores only on write request with a valid address.
// - Memory is read only when all outputs are ready.
// - Memory output carries a valid indication with its data.
// - Each input has producer valid and device ready companions.
// - Each result output has device valid and consumer ready.
// - Read counter supplies next read index, wrapping with memory size.
// - Result outputs hold steady while the consumer is not ready.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
module lrc_loop_ctrl #(
  parameter int DATA_W   = lrc_pkg::LRC_DW,
  parameter int N_OUT    = lrc_pkg::LRC_NOUT,
  parameter int BODY_LAT = lrc_pkg::LRC_BODY_LAT
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire lrc_pkg::lrc_wb_req_t          wb_i,
  output      logic                          wb_ack_o,
  output      logic [31:0]                   wb_dat_o,
  input  wire logic [DATA_W-1:0]             init_data_i,
  input  wire logic                          init_valid_i,
  output      logic                          init_ready_o,
  input  wire logic [DATA_W-1:0]             loop_data_i,
  input  wire logic                          loop_valid_i,
  output      logic                          loop_ready_o,
  input  wire logic                          loop_cond_i,
  input  wire lrc_pkg::lrc_widx_t            loop_widx_i,
  input  wire logic [N_OUT-1:0][DATA_W-1:0]  loop_res_i,
  output      logic [DATA_W-1:0]             body_data_o,
  output      logic                          body_valid_o,
  input  wire logic                          body_ready_i,
  output      lrc_pkg::lrc_widx_t            body_widx_o,
  output      logic [N_OUT-1:0][DATA_W-1:0]  res_data_o,
  output      logic [N_OUT-1:0]              res_valid_o,
  input  wire logic [N_OUT-1:0]              res_ready_i
);
  localparam int AW = lrc_pkg::LRC_AW;

  // Depth check at elaboration
  if (BODY_LAT > lrc_pkg::LRC_DEPTH)
  begin : g_depth_chk
    $error("reorder memory shallower than body latency");
  end

  logic [AW:0]             wr_ptr_q;
  logic [AW:0]             rd_ptr_q;
  logic                    en_q;
  logic [31:0]             done_q;
  logic                    skid_vld_q;
  logic [DATA_W-1:0]       skid_data_q;
  lrc_pkg::lrc_widx_t      skid_widx_q;
  logic                    body_vld_q;
  logic [DATA_W-1:0]       body_data_q;
  lrc_pkg::lrc_widx_t      body_widx_q;
  logic [N_OUT-1:0][DATA_W-1:0] res_data_q;
  logic [N_OUT-1:0]        res_vld_q;
  logic                    ack_q;
  logic [31:0]             dat_q;
  logic [N_OUT-1:0][DATA_W-1:0] mem_data;
  logic [N_OUT-1:0]        mem_vld;

  // Entry selector
  wire use_loop = loop_valid_i & loop_cond_i;
  wire stage_rdy = ~skid_vld_q;
  wire [AW:0] occ = wr_ptr_q - rd_ptr_q;
  wire alloc_ok = en_q & (occ < lrc_pkg::LRC_DEPTH_CNT);
  wire init_take = init_valid_i & init_ready_o;
  wire loop_take = loop_valid_i & loop_ready_o;
  wire [DATA_W-1:0] sel_data = use_loop ? loop_data_i : init_data_i;
  wire sel_valid = use_loop ? loop_take : init_take;
  wire lrc_pkg::lrc_widx_t new_widx = '{vld: 1'b1, idx: wr_ptr_q[AW-1:0]};
  wire lrc_pkg::lrc_widx_t sel_widx = use_loop ? loop_widx_i : new_widx;

  assign init_ready_o = stage_rdy & alloc_ok & ~use_loop;
  assign loop_ready_o = stage_rdy;

  // Exit into reorder memory
  wire mem_wr = loop_take & ~loop_cond_i;
  wire body_free = ~body_vld_q | body_ready_i;

  // Read side
  wire [N_OUT-1:0] out_free = ~res_vld_q | res_ready_i;
  wire all_rdy = &out_free;
  wire mem_ok = &mem_vld;
  wire pop = all_rdy & mem_ok;

  // Register bus decode
  wire wb_req = wb_i.cyc & wb_i.stb;
  wire hit_ctrl = wb_i.adr == lrc_pkg::LRC_ADDR_CTRL;
  wire hit_stat = wb_i.adr == lrc_pkg::LRC_ADDR_STAT;
  wire hit_done = wb_i.adr == lrc_pkg::LRC_ADDR_DONE;
  wire wr_ctrl = wb_req & ack_q & wb_i.we & hit_ctrl & wb_i.sel[0];
  wire loop_idle = (occ == '0) & ~body_vld_q & ~skid_vld_q;
  wire [31:0] stat_w = (32'(occ) << lrc_pkg::LRC_STAT_OCC)
                     | (32'(rd_ptr_q) << lrc_pkg::LRC_STAT_RD)
                     | (32'(wr_ptr_q) << lrc_pkg::LRC_STAT_WR)
                     | (32'(loop_idle) << lrc_pkg::LRC_STAT_IDLE);
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, en_q} :
                       hit_stat ? stat_w :
                       hit_done ? done_q : 32'h0;

  // Write index allocator
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_ptr_q <= '0;
    else if (init_take)
      wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
  end

  // Read index counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_ptr_q <= '0;
    else if (pop)
      rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
  end

  // Skid entry toward body
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      skid_vld_q <= 1'b0;
    else if (skid_vld_q & body_ready_i)
      skid_vld_q <= 1'b0;
    else if ((sel_valid & use_loop | init_take) & ~body_free)
      skid_vld_q <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if ((sel_valid & use_loop | init_take) & stage_rdy & ~body_free)
    begin
      skid_data_q <= sel_data;
      skid_widx_q <= sel_widx;
    end
  end

  // Output register toward body
  wire push = (use_loop & loop_take) | init_take;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      body_vld_q <= 1'b0;
    else if (body_free)
      body_vld_q <= skid_vld_q | push;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      body_widx_q <= '0;
    else if (body_free & skid_vld_q)
      body_widx_q <= skid_widx_q;
    else if (body_free & push)
      body_widx_q <= sel_widx;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      body_data_q <= '0;
    else if (body_free & skid_vld_q)
      body_data_q <= skid_data_q;
    else if (body_free & push)
      body_data_q <= sel_data;
  end

  // One reorder memory and result register per output
  for (genvar o = 0; o < N_OUT; o++)
  begin : g_out
    lrc_reorder_mem #(
      .DATA_W (DATA_W)
    ) u_mem (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .wr_i       (mem_wr),
      .wr_addr_i  (loop_widx_i),
      .wr_data_i  (loop_res_i[o]),
      .rd_en_i    (pop),
      .rd_addr_i  (rd_ptr_q[AW-1:0]),
      .rd_data_o  (mem_data[o]),
      .rd_valid_o (mem_vld[o])
    );

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        res_vld_q[o] <= 1'b0;
      else if (pop)
        res_vld_q[o] <= 1'b1;
      else if (res_ready_i[o])
        res_vld_q[o] <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        res_data_q[o] <= '0;
      else if (pop)
        res_data_q[o] <= mem_data[o];
    end
  end

  // Register file
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_q <= lrc_pkg::LRC_EN_RST;
    else if (wr_ctrl)
      en_q <= wb_i.dat[lrc_pkg::LRC_CTRL_EN];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_q <= 32'h0;
    else if (pop)
      done_q <= done_q + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= wb_req & ~ack_q;
      dat_q <= (wb_req & ~ack_q & ~wb_i.we) ? rd_mux : 32'h0;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign body_data_o  = body_data_q;
  assign body_valid_o = body_vld_q;
  assign body_widx_o  = body_widx_q;
  assign res_data_o   = res_data_q;
  assign res_valid_o  = res_vld_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sel_loop_a: assert property (use_loop |-> !init_ready_o)
    else $error("initial operand accepted during recirculation");
  init_route_a: assert property (init_take |=> body_valid_o &&
    (body_widx_o == $past(new_widx) || skid_vld_q || $past(body_vld_q)))
    else $error("accepted item not routed to body");
  alloc_full_a: assert property ((occ == lrc_pkg::LRC_DEPTH_CNT) |-> !init_ready_o)
    else $error("slot handed out with memory full");
  wr_adv_a: assert property (init_take |=> wr_ptr_q == $past(wr_ptr_q) + 4'h1)
    else $error("write index did not advance");
  ready_slot_a: assert property (init_ready_o |-> en_q && occ < lrc_pkg::LRC_DEPTH_CNT)
    else $error("ready without free slot");
  rd_adv_a: assert property (pop |=> rd_ptr_q == $past(rd_ptr_q) + 4'h1)
    else $error("read index did not advance");
  rd_hold_a: assert property (!pop |=> $stable(rd_ptr_q))
    else $error("read index moved without read");
  out_hold_a: assert property ((res_valid_o[0] && !res_ready_i[0]) |=>
    res_valid_o[0] && $stable(res_data_o[0]))
    else $error("result changed while stalled");
  out_valid_a: assert property (pop |=> &res_valid_o)
    else $error("read without valid results");
  body_hold_a: assert property ((body_valid_o && !body_ready_i) |=>
    body_valid_o && $stable(body_data_o) && $stable(body_widx_o))
    else $error("body data changed before transfer");

  // Entry side
  sel_data_a: assert property ((loop_take && loop_cond_i && body_free) |=>
    body_data_o == $past(loop_data_i))
    else $error("recirculated operand not forwarded");
  init_data_a: assert property ((init_take && body_free) |=>
    body_data_o == $past(init_data_i))
    else $error("initial operand not forwarded");
  widx_loop_a: assert property ((loop_take && loop_cond_i && body_free) |=>
    body_widx_o == $past(loop_widx_i))
    else $error("write index lost on recirculation");
  widx_vld_a: assert property (body_valid_o |->
    body_widx_o.vld)
    else $error("item in body without valid index");
  en_gate_a: assert property (!en_q |->
    !init_ready_o)
    else $error("initial operand accepted while disabled");
  wr_hold_a: assert property (!init_take |=>
    $stable(wr_ptr_q))
    else $error("write index moved without allocation");
  occ_inc_a: assert property ((init_take && !pop) |=>
    occ == $past(occ) + 4'h1)
    else $error("occupancy not raised by allocation");
  occ_dec_a: assert property ((pop && !init_take) |=>
    occ == $past(occ) - 4'h1)
    else $error("occupancy not lowered by read");
  wr_wrap_a: assert property ((init_take && &wr_ptr_q[AW-1:0]) |=>
    wr_ptr_q[AW-1:0] == '0)
    else $error("write index did not wrap");

  // Read side
  rd_ready_a: assert property (!(&(~res_valid_o | res_ready_i)) |=>
    $stable(rd_ptr_q))
    else $error("read index moved with an output busy");
  rd_wait_a: assert property ((all_rdy && !mem_ok) |=>
    $stable(rd_ptr_q))
    else $error("read index moved without valid data");
  rd_wrap_a: assert property ((pop && &rd_ptr_q[AW-1:0]) |=>
    rd_ptr_q[AW-1:0] == '0)
    else $error("read index did not wrap");
  res_load_a: assert property ((|(res_valid_o & ~res_ready_i)) |=>
    $stable(res_data_o))
    else $error("memory read with an output stalled");
  res_hold1_a: assert property ((res_valid_o[1] && !res_ready_i[1]) |=>
    res_valid_o[1])
    else $error("result valid dropped before accepted");
  res_pair_a: assert property ($rose(res_valid_o[0]) |->
    res_valid_o[1])
    else $error("outputs not loaded together");
  res_src_a: assert property ($rose(res_valid_o[0]) |->
    $past(mem_ok))
    else $error("result loaded without valid memory data");

  init_take_c: cover property (init_take);
  exit_write_c: cover property (mem_wr ##1 pop);
  full_c: cover property (occ == lrc_pkg::LRC_DEPTH_CNT);
  recirc_c: cover property (use_loop && loop_take && init_valid_i);
  wrap_c: cover property (pop && &rd_ptr_q[AW-1:0]);
endmodule

// *** test/lrc_body_model.sv ***
module lrc_body_model #(
  parameter int LAT  = 4,
  parameter int NOUT = 2
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [31:0]           body_data_i,
  input  wire logic                  body_valid_i,
  output      logic                  body_ready_o,
  input  wire lrc_pkg::lrc_widx_t    body_widx_i,
  output      logic [31:0]           loop_data_o,
  output      logic                  loop_valid_o,
  input  wire logic                  loop_ready_i,
  output      logic                  loop_cond_o,
  output      lrc_pkg::lrc_widx_t    loop_widx_o,
  output      logic [NOUT-1:0][31:0] loop_res_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAT-1:0]     v_q;
  logic [31:0]        d_q [LAT];
  lrc_pkg::lrc_widx_t w_q [LAT];
  wire  logic         adv   = !(v_q[LAT-1] && !loop_ready_i); // Stall holds item
  wire  logic [31:0]  out_d = v_q[LAT-1] ? d_q[LAT-1] : ~d_q[LAT-1];

  assign body_ready_o = adv;
  assign loop_valid_o = v_q[LAT-1];
  assign loop_data_o  = out_d;
  assign loop_widx_o  = w_q[LAT-1];
  assign loop_cond_o  = v_q[LAT-1] && (out_d[15:0] != 16'h0000);
  always_comb
    for (int k = 0; k < NOUT; k++)
      loop_res_o[k] = {out_d[31:16], 16'(k)};

  // Low half counts remaining passes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      v_q <= '0;
    else if (adv)
    begin
      v_q    <= {v_q[LAT-2:0], body_valid_i};
      d_q[0] <= body_data_i - 32'h1;
      w_q[0] <= body_widx_i;
      for (int s = 1; s < LAT; s++)
      begin
        d_q[s] <= d_q[s-1];
        w_q[s] <= w_q[s-1];
      end
    end
  end
endmodule

// *** test/lrc_loop_ctrl_test.sv ***
module lrc_loop_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i;
  logic                 rst_i;
  lrc_pkg::lrc_wb_req_t wb_i;
  logic                 wb_ack_o;
  logic [31:0]          wb_dat_o;
  logic [31:0]          init_data_i;
  logic                 init_valid_i;
  logic                 init_ready_o;
  logic [31:0]          body_data;
  logic                 body_valid;
  logic                 body_ready;
  lrc_pkg::lrc_widx_t   body_widx;
  logic [31:0]          loop_data;
  logic                 loop_valid;
  logic                 loop_ready;
  logic                 loop_cond;
  lrc_pkg::lrc_widx_t   loop_widx;
  logic [1:0][31:0]     loop_res;
  logic [1:0][31:0]     res_data_o;
  logic [1:0]           res_valid_o;
  logic [1:0]           res_ready_i;
  logic [15:0]          exp_id [$];
  int                   got [2];
  logic [31:0]          hold_d [2];
  bit                   hold_f [2];
  int                   n_errors;
  int                   checks;
  logic [15:0]          iters [12] = '{16'h3, 16'h1, 16'h4, 16'h1, 16'h2, 16'h5,
                                       16'h1, 16'h2, 16'h3, 16'h1, 16'h1, 16'h4};

  lrc_loop_ctrl #(.DATA_W(32), .N_OUT(2), .BODY_LAT(4)) lrc_loop_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .init_data_i(init_data_i), .init_valid_i(init_valid_i), .init_ready_o(init_ready_o),
    .loop_data_i(loop_data), .loop_valid_i(loop_valid), .loop_ready_o(loop_ready),
    .loop_cond_i(loop_cond), .loop_widx_i(loop_widx), .loop_res_i(loop_res),
    .body_data_o(body_data), .body_valid_o(body_valid), .body_ready_i(body_ready),
    .body_widx_o(body_widx), .res_data_o(res_data_o), .res_valid_o(res_valid_o),
    .res_ready_i(res_ready_i));

  lrc_body_model #(.LAT(4), .NOUT(2)) lrc_body_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .body_data_i(body_data), .body_valid_i(body_valid),
    .body_ready_o(body_ready), .body_widx_i(body_widx), .loop_data_o(loop_data),
    .loop_valid_o(loop_valid), .loop_ready_i(loop_ready), .loop_cond_o(loop_cond),
    .loop_widx_o(loop_widx), .loop_res_o(loop_res));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb_do(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic send(input logic [15:0] id, input logic [15:0] it, input int lim,
                      output bit ok);
    int n;
    n = 0;
    init_data_i  <= {id, it};
    init_valid_i <= 1'b1;
    do
      @(posedge clk_i);
    while (init_ready_o !== 1'b1 && ++n < lim);
    ok = (n < lim);
    if (ok)
      exp_id.push_back(id);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((got[0] != exp_id.size() || got[1] != exp_id.size()) && n++ < 3000)
      @(posedge clk_i);
    check("delivered", 32'(got[0] + got[1]), 32'(2 * exp_id.size()));
  endtask

  // Consumer side: order and hold checks per output
  always @(posedge clk_i)
    for (int k = 0; k < 2; k++)
    begin
      if (hold_f[k])
        check("held result", res_data_o[k], hold_d[k]);
      hold_f[k] = res_valid_o[k] === 1'b1 && res_ready_i[k] !== 1'b1;
      hold_d[k] = res_data_o[k];
      if (res_valid_o[k] === 1'b1 && res_ready_i[k] === 1'b1)
      begin
        check("result", res_data_o[k], {exp_id[got[k]], 16'(k)});
        got[k]++;
      end
    end

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    #300us;
    n_errors++;
    close_out();
  end

  initial
  begin
    logic [31:0] d;
    bit          ok;
    int          acc;
    rst_i = 1'b1;
    wb_i = '0;
    init_data_i = '0;
    init_valid_i = 1'b0;
    res_ready_i = 2'b11;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_do(1'b0, lrc_pkg::LRC_ADDR_CTRL, 32'h0, d);
    check("ctrl reset", d & 32'h1, 32'(lrc_pkg::LRC_EN_RST));
    check("ready at reset", 32'(init_ready_o), 32'h1);
    wb_do(1'b1, lrc_pkg::LRC_ADDR_CTRL, 32'h0, d);
    check("ready disabled", 32'(init_ready_o), 32'h0);
    wb_do(1'b0, 4'hc, 32'h0, d);
    check("unmapped", d, 32'h0);
    wb_do(1'b1, lrc_pkg::LRC_ADDR_CTRL, 32'h1, d);
    $display("test registers done");
    foreach (iters[i])
    begin
      send(16'(i + 1), iters[i], 2000, ok);
      check("accepted", 32'(ok), 32'h1);
    end
    init_valid_i <= 1'b0;
    drain();
    $display("test reorder done");
    res_ready_i <= 2'b00;
    acc = 0;
    do
      send(16'(100 + acc), 16'h1, 40, ok);
    while (ok && ++acc < 12);
    check("admitted", 32'(acc), 32'h9);
    check("outputs valid", 32'(res_valid_o), 32'h3);
    res_ready_i <= 2'b11;
    send(16'(100 + acc), 16'h1, 100, ok);
    check("admitted after read", 32'(ok), 32'h1);
    init_valid_i <= 1'b0;
    drain();
    $display("test full memory done");
    wb_do(1'b0, lrc_pkg::LRC_ADDR_STAT, 32'h0, d);
    check("status", d, 32'h0106_0600);
    wb_do(1'b0, lrc_pkg::LRC_ADDR_DONE, 32'h0, d);
    check("done count", d, 32'h16);
    $display("test status done");
    close_out();
  end
endmodule
